// ==== logic/mbh_pkg.sv ====
// shared constants and types of the modbus host bridge
package mbh_pkg;
  localparam int CLK_NS = 10;
  localparam int TICK_NS = 10000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_FUNC = 12'h004;
  localparam logic [11:0] OFS_RETRY = 12'h008;
  localparam logic [11:0] OFS_BIAS = 12'h00C;
  localparam logic [11:0] OFS_IVL = 12'h010;
  localparam logic [11:0] OFS_ROUTE = 12'h014;
  localparam logic [11:0] OFS_RD_LEN = 12'h018;
  localparam logic [11:0] OFS_RD_SRC = 12'h01C;
  localparam logic [11:0] OFS_RD_DST = 12'h020;
  localparam logic [11:0] OFS_WR_LEN = 12'h024;
  localparam logic [11:0] OFS_WR_DST = 12'h028;
  localparam logic [11:0] OFS_WR_SRC = 12'h02C;
  localparam logic [11:0] OFS_TMO = 12'h030;
  localparam logic [11:0] OFS_STATUS = 12'h034;
  localparam logic [3:0] MBOX_PAGE = 4'h1;
  localparam int FUNC_WR_LSB = 8;
  localparam int ROUTE_UNIT_LSB = 8;
  localparam int TRY_LSB = 16;
  localparam logic [7:0] FC_RD_MIN = 8'h01;
  localparam logic [7:0] FC_RD_MAX = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_REG = 8'h06;
  localparam logic [7:0] FC_WR_MCOIL = 8'h0F;
  localparam logic [7:0] FC_WR_MREG = 8'h10;
  localparam logic [13:0] NREG_MAX = 14'h2000;
  localparam logic [7:0] RST_RD_FC = 8'h04;
  localparam logic [7:0] RST_WR_FC = 8'h10;
  localparam logic [15:0] RST_RETRY = 16'h0064;
  localparam logic [15:0] RST_BIAS = 16'h0001;
  localparam logic [15:0] RST_IVL = 16'h0064;
  localparam logic [15:0] RST_TMO = 16'h01F4;
  localparam logic [3:0] RST_TRIES = 4'h3;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_REQ = 3'b001, S_WDAT = 3'b010,
    S_WAIT = 3'b011, S_RETRY = 3'b100
  } eng_state_t;
  typedef enum logic [1:0] {
    J_NAT = 2'b00, J_ARD = 2'b01, J_AWR = 2'b10
  } job_src_t;
  typedef struct packed {
    logic valid; logic write; logic [13:0] reg_num;
    logic [7:0] unit; logic [15:0] wdata;
  } nat_req_t;
  typedef struct packed {
    logic valid; logic ok; logic [15:0] rdata;
  } nat_rsp_t;
  typedef struct packed {
    logic valid; logic [7:0] fc; logic [7:0] drop; logic [7:0] unit;
    logic [15:0] addr; logic [7:0] count;
  } link_req_t;
  typedef struct packed {
    logic valid; logic [15:0] data;
  } link_wr_t;
  typedef struct packed {
    logic rvalid; logic [15:0] rdata; logic done; logic ok;
  } link_rsp_t;
  typedef struct packed {
    logic auto_en; logic [7:0] rd_fc; logic [7:0] wr_fc;
    logic [15:0] retry; logic [15:0] bias; logic [15:0] ivl;
    logic [15:0] tmo; logic [3:0] tries; logic [7:0] drop;
    logic [7:0] unit; logic [7:0] rd_len; logic [15:0] rd_src;
    logic [15:0] rd_dst; logic [7:0] wr_len; logic [15:0] wr_dst;
    logic [15:0] wr_src;
  } cfg_t;
  localparam cfg_t CFG_RST = '{auto_en: 1'b0, rd_fc: RST_RD_FC,
    wr_fc: RST_WR_FC, retry: RST_RETRY, bias: RST_BIAS, ivl: RST_IVL,
    tmo: RST_TMO, tries: RST_TRIES, drop: 8'h00, unit: 8'h00,
    rd_len: 8'h00, rd_src: 16'h0001, rd_dst: 16'h0001, wr_len: 8'h00,
    wr_dst: 16'h0001, wr_src: 16'h0001};
  typedef struct packed {
    cfg_t cfg; eng_state_t st; job_src_t src; logic wr;
    logic [15:0] addr; logic [7:0] fc; logic [7:0] unit;
    logic [7:0] cnt; logic [7:0] idx; logic [15:0] mb;
    logic [15:0] wdat; logic [15:0] tmr; logic [3:0] tries;
    logic rd_pend; logic wr_pend; logic [15:0] ivl_cnt;
    logic [31:0] tick_cnt; logic tick; logic [7:0] rejects;
    logic [7:0] fails; logic [11:0] ahb_a; logic ahb_w; logic ahb_ph;
    logic hready; logic [31:0] hrdata; logic nreq_ready;
    nat_rsp_t nrsp; link_req_t lreq; link_wr_t lwr;
  } core_t;
endpackage

// ==== logic/mbh_bridge.sv ====
// modbus host bridge with periodic auto-transfer engine
//
// Functional notes
// - native reads use configured read code, default 4
// - native writes use configured write code, default 16
// - failed transfer waits retry delay before resending
// - link address is register plus bias minus one
// - bias resets to one
// - auto-transfer starts every interval of ticks
// - auto route is own drop then unit
// - read length zero none, one single read
// - longer read covers consecutive peripheral registers
// - read data lands in consecutive mailbox words
// - write length zero none, one single write
// - longer write covers consecutive peripheral registers
// - write data comes from consecutive mailbox words
`timescale 1ns/100ps
`default_nettype none
module mbh_bridge
  import mbh_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter int MBOX_AW = 6
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire nat_req_t nreq,
  output logic nreq_ready,
  output nat_rsp_t nrsp,
  output link_req_t lk_req,
  input wire logic lk_req_ready,
  output link_wr_t lk_wr,
  input wire logic lk_wready,
  input wire link_rsp_t lk_rsp
);
  core_t c;
  core_t n;
  logic [15:0] mbox [0:(1 << MBOX_AW) - 1];
  logic mb_we;
  logic [MBOX_AW-1:0] mb_wa;
  logic [15:0] mb_wd;
  logic [MBOX_AW-1:0] ahb_mi;
  logic ahb_mb;
  logic fire;
  logic rj_r;
  logic rj_w;
  logic fail;
  logic fin;
  logic fin_ok;
  logic acc;

  assign hreadyout = c.hready;
  assign hresp = 1'b0;
  assign hrdata = c.hrdata;
  assign nreq_ready = c.nreq_ready;
  assign nrsp = c.nrsp;
  assign lk_req = c.lreq;
  assign lk_wr = c.lwr;
  assign ahb_mi = c.ahb_a[MBOX_AW+1:2];
  assign ahb_mb = (c.ahb_a[11:8] == MBOX_PAGE);

  always_comb begin
    n = c;
    fire = 1'b0;
    rj_r = 1'b0;
    rj_w = 1'b0;
    fail = 1'b0;
    fin = 1'b0;
    fin_ok = 1'b0;
    mb_we = 1'b0;
    mb_wa = MBOX_AW'(c.mb + 16'(c.idx));
    mb_wd = lk_rsp.rdata;
    n.nrsp.valid = 1'b0;
    n.tick = 1'b0;
    // hundredth-second tick
    if (c.tick_cnt == 32'(TICK_CYCLES - 1)) begin
      n.tick_cnt = 32'h0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = c.tick_cnt + 32'h1;
    end
    // interval timer
    if (!c.cfg.auto_en) begin
      n.ivl_cnt = 16'h0;
    end else if (c.tick) begin
      if (c.ivl_cnt >= c.cfg.ivl - 16'h1) begin
        n.ivl_cnt = 16'h0;
        fire = 1'b1;
      end else begin
        n.ivl_cnt = c.ivl_cnt + 16'h1;
      end
    end
    // engine
    case (c.st)
      S_IDLE: begin
        if (nreq.valid && c.nreq_ready) begin
          if (nreq.reg_num == 14'h0 || nreq.reg_num > NREG_MAX) begin
            n.nrsp.valid = 1'b1;
            n.nrsp.ok = 1'b0;
          end else begin
            n.src = J_NAT;
            n.wr = nreq.write;
            n.addr = 16'(nreq.reg_num) + c.cfg.bias - 16'h1;
            n.fc = nreq.write ? c.cfg.wr_fc : c.cfg.rd_fc;
            n.unit = nreq.unit;
            n.cnt = 8'h1;
            n.wdat = nreq.wdata;
            n.tries = 4'h0;
            n.st = S_REQ;
          end
        end else if (c.rd_pend) begin
          n.src = J_ARD;
          n.wr = 1'b0;
          n.addr = c.cfg.rd_src + c.cfg.bias - 16'h1;
          n.fc = c.cfg.rd_fc;
          n.unit = c.cfg.unit;
          n.cnt = c.cfg.rd_len;
          n.mb = c.cfg.rd_dst - 16'h1;
          n.tries = 4'h0;
          n.st = S_REQ;
        end else if (c.wr_pend) begin
          n.src = J_AWR;
          n.wr = 1'b1;
          n.addr = c.cfg.wr_dst + c.cfg.bias - 16'h1;
          n.fc = c.cfg.wr_fc;
          if (c.cfg.wr_len > 8'h1) begin
            if (c.cfg.wr_fc == FC_WR_COIL || c.cfg.wr_fc == FC_WR_MCOIL)
            begin
              n.fc = FC_WR_MCOIL;
            end else begin
              n.fc = FC_WR_MREG;
            end
          end
          n.unit = c.cfg.unit;
          n.cnt = c.cfg.wr_len;
          n.mb = c.cfg.wr_src - 16'h1;
          n.tries = 4'h0;
          n.st = S_REQ;
        end
      end
      S_REQ: begin
        if (lk_req_ready) begin
          n.lreq.valid = 1'b0;
          n.idx = 8'h0;
          n.tmr = 16'h0;
          if (c.wr) begin
            n.lwr.valid = 1'b1;
            n.lwr.data = (c.src == J_NAT) ? c.wdat
                         : mbox[MBOX_AW'(c.mb)];
            n.st = S_WDAT;
          end else begin
            n.st = S_WAIT;
          end
        end
      end
      S_WDAT: begin
        if (lk_wready) begin
          n.idx = c.idx + 8'h1;
          if (c.idx + 8'h1 == c.cnt) begin
            n.lwr.valid = 1'b0;
            n.st = S_WAIT;
          end else begin
            n.lwr.data = mbox[MBOX_AW'(c.mb + 16'(c.idx) + 16'h1)];
          end
        end
      end
      S_WAIT: begin
        if (c.tick) begin
          n.tmr = c.tmr + 16'h1;
        end
        if (lk_rsp.rvalid && !c.wr && c.idx < c.cnt) begin
          n.idx = c.idx + 8'h1;
          if (c.src == J_ARD) begin
            mb_we = 1'b1;
          end else if (c.idx == 8'h0) begin
            n.nrsp.rdata = lk_rsp.rdata;
          end
        end
        if (lk_rsp.done) begin
          fin_ok = lk_rsp.ok;
          fin = lk_rsp.ok;
          fail = !lk_rsp.ok;
        end else if (c.tick && c.tmr == c.cfg.tmo) begin
          fail = 1'b1;
        end
      end
      S_RETRY: begin
        if (c.tick) begin
          if (c.tmr == c.cfg.retry) begin
            n.st = S_REQ;
          end else begin
            n.tmr = c.tmr + 16'h1;
          end
        end
      end
      default: begin
        n.st = S_IDLE;
      end
    endcase
    if (fail) begin
      if (c.tries < c.cfg.tries) begin
        n.tries = c.tries + 4'h1;
        n.tmr = 16'h0;
        n.st = S_RETRY;
      end else begin
        fin = 1'b1;
        n.fails = c.fails + 8'h1;
      end
    end
    if (fin) begin
      n.st = S_IDLE;
      if (c.src == J_NAT) begin
        n.nrsp.valid = 1'b1;
        n.nrsp.ok = fin_ok;
      end
      if (c.src == J_ARD) begin
        n.rd_pend = 1'b0;
      end
      if (c.src == J_AWR) begin
        n.wr_pend = 1'b0;
      end
    end
    // periodic launch, zero length disables a direction
    if (fire && c.cfg.rd_len != 8'h0) begin
      if (n.rd_pend) begin
        rj_r = 1'b1;
      end else begin
        n.rd_pend = 1'b1;
      end
    end
    if (fire && c.cfg.wr_len != 8'h0) begin
      if (n.wr_pend) begin
        rj_w = 1'b1;
      end else begin
        n.wr_pend = 1'b1;
      end
    end
    n.rejects = c.rejects + 8'(rj_r) + 8'(rj_w);
    if (c.st != S_REQ && n.st == S_REQ) begin
      n.lreq.valid = 1'b1;
      n.lreq.fc = n.fc;
      n.lreq.drop = c.cfg.drop;
      n.lreq.unit = n.unit;
      n.lreq.addr = n.addr;
      n.lreq.count = n.cnt;
    end
    n.nreq_ready = (n.st == S_IDLE);
    // ahb data phase, one wait state
    if (c.ahb_ph) begin
      n.ahb_ph = 1'b0;
      n.hready = 1'b1;
      n.hrdata = 32'h0;
      if (c.ahb_w) begin
        case (c.ahb_a)
          OFS_CTRL: n.cfg.auto_en = hwdata[0];
          OFS_FUNC: begin
            if (hwdata[7:0] >= FC_RD_MIN && hwdata[7:0] <= FC_RD_MAX)
            begin
              n.cfg.rd_fc = hwdata[7:0];
            end
            if (hwdata[15:8] inside {FC_WR_COIL, FC_WR_REG,
                                     FC_WR_MCOIL, FC_WR_MREG}) begin
              n.cfg.wr_fc = hwdata[15:8];
            end
          end
          OFS_RETRY: begin
            n.cfg.retry = hwdata[15:0];
            n.cfg.tries = hwdata[TRY_LSB+3:TRY_LSB];
          end
          OFS_BIAS: n.cfg.bias = hwdata[15:0];
          OFS_IVL: n.cfg.ivl = hwdata[15:0];
          OFS_ROUTE: begin
            n.cfg.drop = hwdata[7:0];
            n.cfg.unit = hwdata[ROUTE_UNIT_LSB+7:ROUTE_UNIT_LSB];
          end
          OFS_RD_LEN: n.cfg.rd_len = hwdata[7:0];
          OFS_RD_SRC: n.cfg.rd_src = hwdata[15:0];
          OFS_RD_DST: n.cfg.rd_dst = hwdata[15:0];
          OFS_WR_LEN: n.cfg.wr_len = hwdata[7:0];
          OFS_WR_DST: n.cfg.wr_dst = hwdata[15:0];
          OFS_WR_SRC: n.cfg.wr_src = hwdata[15:0];
          OFS_TMO: n.cfg.tmo = hwdata[15:0];
          default: begin
            if (ahb_mb && !mb_we) begin
              mb_we = 1'b1;
              mb_wa = ahb_mi;
              mb_wd = hwdata[15:0];
            end
          end
        endcase
      end else begin
        case (c.ahb_a)
          OFS_CTRL: n.hrdata = 32'(c.cfg.auto_en);
          OFS_FUNC: n.hrdata = {16'h0, c.cfg.wr_fc, c.cfg.rd_fc};
          OFS_RETRY: n.hrdata = {12'h0, c.cfg.tries, c.cfg.retry};
          OFS_BIAS: n.hrdata = {16'h0, c.cfg.bias};
          OFS_IVL: n.hrdata = {16'h0, c.cfg.ivl};
          OFS_ROUTE: n.hrdata = {16'h0, c.cfg.unit, c.cfg.drop};
          OFS_RD_LEN: n.hrdata = {24'h0, c.cfg.rd_len};
          OFS_RD_SRC: n.hrdata = {16'h0, c.cfg.rd_src};
          OFS_RD_DST: n.hrdata = {16'h0, c.cfg.rd_dst};
          OFS_WR_LEN: n.hrdata = {24'h0, c.cfg.wr_len};
          OFS_WR_DST: n.hrdata = {16'h0, c.cfg.wr_dst};
          OFS_WR_SRC: n.hrdata = {16'h0, c.cfg.wr_src};
          OFS_TMO: n.hrdata = {16'h0, c.cfg.tmo};
          OFS_STATUS: n.hrdata = {c.fails, c.rejects, 11'h0,
                                  c.st, c.wr_pend, c.rd_pend};
          default: begin
            if (ahb_mb) begin
              n.hrdata = {16'h0, mbox[ahb_mi]};
            end
          end
        endcase
      end
    end
    acc = hsel && htrans[1] && hready && hsize == 3'b010;
    if (hsel && htrans[1] && hready) begin
      n.ahb_ph = 1'b1;
      n.ahb_a = {haddr[11:2], 2'b00};
      n.ahb_w = hwrite && acc;
      n.hready = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      c <= '0;
      c.cfg <= CFG_RST;
      c.hready <= 1'b1;
    end else begin
      c <= n;
    end
  end

  always_ff @(posedge mclk) begin
    if (mb_we) begin
      mbox[mb_wa] <= mb_wd;
    end
  end
endmodule
`default_nettype wire

// ==== verification/mbh_chk_sva.sv ====
// port checker of the modbus host bridge
`timescale 1ns/100ps
`default_nettype none
module mbh_chk
  import mbh_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire nat_req_t nreq,
  input wire logic nreq_ready,
  input wire nat_rsp_t nrsp,
  input wire link_req_t lk_req,
  input wire logic lk_req_ready,
  input wire link_wr_t lk_wr,
  input wire logic lk_wready,
  input wire link_rsp_t lk_rsp
);
  logic take;
  assign take = nreq.valid && nreq_ready;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  ahb_wait_a: assert property (hsel && htrans[1] && hready
    |=> !hreadyout ##1 hreadyout) else $error("bad wait state");
  fc_legal_a: assert property (lk_req.valid |->
    lk_req.fc inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F,
    8'h10}) else $error("illegal function code");
  oor_reject_a: assert property (take && (nreq.reg_num == 14'h0000 ||
    nreq.reg_num > 14'h2000) |-> ##[1:2] nrsp.valid && !nrsp.ok)
    else $error("range not refused");
  req_hold_a: assert property (lk_req.valid && !lk_req_ready
    |=> lk_req.valid && $stable(lk_req)) else $error("header dropped");
  wr_hold_a: assert property (lk_wr.valid && !lk_wready
    |=> lk_wr.valid && $stable(lk_wr)) else $error("word dropped");
  one_job_a: assert property (lk_req.valid && lk_req_ready
    |=> !lk_req.valid) else $error("header overlap");
  busy_a: assert property (lk_req.valid |-> !nreq_ready)
    else $error("ready while busy");
  nrsp_pulse_a: assert property (nrsp.valid |=> !nrsp.valid)
    else $error("answer too long");
  rst_quiet_a: assert property (disable iff (1'b0) sys_rst |=> hreadyout
    && !nreq_ready && !lk_req.valid && !lk_wr.valid && !nrsp.valid)
    else $error("reset state wrong");
  cover property (take && !nreq.write);
  cover property (lk_req.valid && lk_req.count > 8'h01);
  cover property (lk_rsp.done && !lk_rsp.ok);
endmodule
bind mbh_bridge mbh_chk chk_u (.mclk(mclk), .sys_rst(sys_rst),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .nreq(nreq), .nreq_ready(nreq_ready), .nrsp(nrsp), .lk_req(lk_req),
  .lk_req_ready(lk_req_ready), .lk_wr(lk_wr), .lk_wready(lk_wready),
  .lk_rsp(lk_rsp));
`default_nettype wire

// ==== verification/link_slave_model.sv ====
// modbus slave model at the far side of the link
`timescale 1ns/100ps
`default_nettype none
module link_slave_model
  import mbh_pkg::*;
(
  input wire logic mclk,
  input wire logic [1:0] slow,
  input wire link_req_t lk_req,
  output logic lk_req_ready,
  input wire link_wr_t lk_wr,
  output logic lk_wready,
  output link_rsp_t lk_rsp,
  output link_req_t hdr,
  output logic [31:0] wds,
  output logic [15:0] nhdr
);
  link_req_t h;
  logic [7:0] k;
  logic bad_done;
  initial begin
    lk_req_ready = 1'b0;
    lk_wready = 1'b0;
    lk_rsp = '0;
    hdr = '0;
    wds = '0;
    nhdr = '0;
    bad_done = 1'b0;
    forever begin
      @(posedge mclk);
      lk_rsp.done <= 1'b0;
      lk_rsp.rdata <= ~lk_rsp.rdata;
      if (lk_req.valid === 1'b1) begin
        repeat (slow) @(posedge mclk);
        lk_req_ready <= 1'b1;
        @(posedge mclk);
        h = lk_req;
        lk_req_ready <= 1'b0;
        hdr <= h;
        nhdr <= nhdr + 16'h0001;
        if (h.fc > 8'h04) begin
          repeat (slow) @(posedge mclk);
          lk_wready <= 1'b1;
          for (k = 8'h00; k < h.count; k++) begin
            do @(posedge mclk); while (lk_wr.valid !== 1'b1);
            wds <= {wds[15:0], lk_wr.data};
          end
          lk_wready <= 1'b0;
        end
        for (k = 8'h00; k < h.count && h.fc < 8'h05; k++) begin
          lk_rsp.rvalid <= 1'b1;
          lk_rsp.rdata <= (h.addr + {8'h00, k}) ^ 16'hA500;
          @(posedge mclk);
        end
        lk_rsp.rvalid <= 1'b0;
        lk_rsp.done <= 1'b1;
        lk_rsp.ok <= !(h.addr == 16'h0BAD && !bad_done);
        bad_done = bad_done || h.addr == 16'h0BAD;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/test_modbus_host_autotransfer.sv ====
// self-checking bench of the modbus host bridge
`timescale 1ns/100ps
`default_nettype none
module test_modbus_host_autotransfer
  import mbh_pkg::*;
;
  localparam int TK = 20;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, nreq_ready, lk_req_ready, lk_wready;
  logic [31:0] hrdata, q, wds;
  nat_req_t nreq = '0;
  nat_rsp_t nrsp;
  link_req_t lk_req, hdr;
  link_wr_t lk_wr;
  link_rsp_t lk_rsp;
  logic [1:0] slow = 2'h0;
  logic [15:0] nhdr, n0;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  time t_fail, t_hdr, t0;
  logic [11:0] ra [5] = '{OFS_FUNC, OFS_RETRY, OFS_BIAS, OFS_IVL, 12'h0FC};
  logic [31:0] rv [5] = '{32'h00001004, 32'h00030064, 32'h00000001,
    32'h00000064, 32'h00000000};
  logic [7:0] wfc [4] = '{8'h05, 8'h06, 8'h0F, 8'h10};
  logic [11:0] ca [10] = '{OFS_ROUTE, OFS_RD_LEN, OFS_RD_SRC, OFS_RD_DST,
    OFS_WR_LEN, OFS_WR_DST, OFS_WR_SRC, OFS_IVL, 12'h124, 12'h128};
  logic [15:0] cd [10] = '{16'h0903, 16'h0002, 16'h0005, 16'h0004,
    16'h0002, 16'h0020, 16'h000A, 16'h0005, 16'h1111, 16'h2222};
  always #5 mclk = ~mclk;
  mbh_bridge #(.TICK_CYCLES(TK), .MBOX_AW(6)) dut_u (.mclk(mclk),
    .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .nreq(nreq),
    .nreq_ready(nreq_ready), .nrsp(nrsp), .lk_req(lk_req),
    .lk_req_ready(lk_req_ready), .lk_wr(lk_wr), .lk_wready(lk_wready),
    .lk_rsp(lk_rsp));
  link_slave_model peer_u (.mclk(mclk), .slow(slow), .lk_req(lk_req),
    .lk_req_ready(lk_req_ready), .lk_wr(lk_wr), .lk_wready(lk_wready),
    .lk_rsp(lk_rsp), .hdr(hdr), .wds(wds), .nhdr(nhdr));
  task automatic close_out;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h00000, a};
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic nat(input logic w, input logic [13:0] r,
      input logic [15:0] d);
    do @(posedge mclk); while (nreq_ready !== 1'b1);
    nreq <= '{valid: 1'b1, write: w, reg_num: r, unit: 8'h07, wdata: d};
    do @(posedge mclk); while (nreq_ready !== 1'b1);
    nreq.valid <= 1'b0;
    do @(posedge mclk); while (nrsp.valid !== 1'b1);
  endtask
  task automatic wait_hdr;
    n0 = nhdr;
    do @(posedge mclk); while (nhdr === n0);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (lk_rsp.done === 1'b1 && lk_rsp.ok === 1'b0) t_fail = $time;
    if (lk_req.valid === 1'b1 && lk_req_ready === 1'b1) t_hdr = $time;
    if (cyc == 6000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, ra[i], 32'h0);
      chk(q ^ {hresp, 31'h0}, rv[i]);
    end
    ahb(1'b1, OFS_RETRY, 32'h00030002);
    nat(1'b0, 14'h0001, 16'h0000);
    chk({hdr.fc, hdr.unit, hdr.addr}, 32'h04070001);
    chk({nrsp.ok, nrsp.rdata}, 32'h0001A501);
    ahb(1'b1, OFS_BIAS, 32'h00004E21);
    for (int f = 1; f <= 4; f++) begin
      slow <= 2'(f);
      ahb(1'b1, OFS_FUNC, {16'h0000, 8'h10, 8'(f)});
      nat(1'b0, 14'h000A, 16'h0000);
      chk({hdr.fc, hdr.unit, hdr.addr}, {8'(f), 8'h07, 16'h4E2A});
    end
    ahb(1'b1, OFS_BIAS, 32'h00000001);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, OFS_FUNC, {16'h0000, wfc[i], 8'h04});
      nat(1'b1, 14'h2000, {8'h5A, 8'(i)});
      chk({hdr.fc, hdr.unit, hdr.addr}, {wfc[i], 8'h07, 16'h2000});
      chk({nrsp.ok, wds[15:0]}, {16'h0001, 8'h5A, 8'(i)});
    end
    slow <= 2'h0;
    n0 = nhdr;
    nat(1'b0, 14'h2001, 16'h0000);
    chk({nrsp.ok, nhdr}, {17'h00000, n0});
    nat(1'b0, 14'h0BAD, 16'h0000);
    chk({nrsp.ok, nrsp.rdata}, 32'h0001AEAD);
    t0 = t_hdr - t_fail;
    chk({31'h0, t0 >= 2 * TK * 10 && t0 <= 3 * TK * 10 + 100}, 1);
    for (int i = 0; i < 10; i++) ahb(1'b1, ca[i], {16'h0000, cd[i]});
    ahb(1'b1, OFS_CTRL, 32'h00000001);
    for (int n = 0; n < 2; n++) begin
      wait_hdr();
      t0 = t_hdr - t0;
      chk({hdr.fc, hdr.drop, hdr.unit, hdr.count}, 32'h04030902);
      chk({16'h0000, hdr.addr}, 32'h00000005);
      if (n == 1) chk({31'h0, t0 == 5 * TK * 10}, 1);
      t0 = t_hdr;
      wait_hdr();
      chk({hdr.fc, hdr.drop, hdr.unit, hdr.count}, 32'h10030902);
      do @(posedge mclk); while (lk_rsp.done !== 1'b1);
      chk({hdr.addr, 16'h0000}, 32'h00200000);
      chk(wds, 32'h11112222);
    end
    ahb(1'b1, OFS_CTRL, 32'h00000000);
    ahb(1'b0, 12'h10C, 32'h0);
    chk(q, 32'h0000A505);
    ahb(1'b0, 12'h110, 32'h0);
    chk(q, 32'h0000A506);
    ahb(1'b1, OFS_RD_LEN, 32'h00000000);
    ahb(1'b1, OFS_WR_LEN, 32'h00000001);
    ahb(1'b1, OFS_CTRL, 32'h00000001);
    for (int n = 0; n < 2; n++) begin
      wait_hdr();
      chk({hdr.fc, hdr.count, hdr.addr}, 32'h10010020);
    end
    slow <= 2'h3;
    ahb(1'b1, OFS_RD_LEN, 32'h00000008);
    ahb(1'b1, OFS_IVL, 32'h00000001);
    repeat (200) @(posedge mclk);
    ahb(1'b1, OFS_CTRL, 32'h00000000);
    ahb(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, q[23:16] != 8'h00}, 1);
    close_out();
  end
endmodule
`default_nettype wire
